/* core/drsac_pkg.sv */
// Constants, encodings and register map of the drive ramp, stop and self-tune controller
package drsac_pkg;
    // Clock and control time base
    localparam longint CLK_PERIOD_NS = 64'd10;
    localparam longint CENTI_NS = 64'd10000000;   // 0.01 s, the step of every time setting
    localparam longint CENTI_CYCLES = (CENTI_NS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
    localparam longint TUNE_TIMEOUT_S = 64'd30;
    localparam longint TUNE_TIMEOUT_CYCLES = (TUNE_TIMEOUT_S * 64'd1000000000) / CLK_PERIOD_NS;

    // Register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int VAL_W = 16;
    localparam int TMR_W = 40;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ACCEL = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_DECEL = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_MINF = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_MAXF = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_FREF = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_BRAKE = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_OUTF = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_STATOR = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_FLUX = 8'h28;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STS = 8'h2C;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MSK = 8'h30;

    // Control register fields
    localparam int CTRL_METHOD_LSB = 0;
    localparam int CTRL_TUNE_LSB = 4;
    localparam int CTRL_STOP_LSB = 8;

    // Status register fields
    localparam int STAT_RUN = 0;
    localparam int STAT_TUNING = 1;
    localparam int STAT_BRAKE = 2;
    localparam int STAT_TUNE_FAULT = 3;
    localparam int STAT_EXT_FAULT = 4;
    localparam int STAT_STATE_LSB = 8;

    // Interrupt status and mask bits
    localparam int IRQ_W = 3;
    localparam int IRQ_TUNE_FAULT = 0;
    localparam int IRQ_TUNE_DONE = 1;
    localparam int IRQ_STOPPED = 2;

    // Value limits and reset values (times in 0.01 s, frequencies in 0.01 Hz)
    localparam logic [VAL_W-1:0] TIME_MAX = 16'hEA60;
    localparam logic [VAL_W-1:0] FREQ_LIMIT = 16'hC350;
    localparam logic [VAL_W-1:0] ACCEL_RST = 16'h03E8;
    localparam logic [VAL_W-1:0] DECEL_RST = 16'h03E8;
    localparam logic [VAL_W-1:0] MINF_RST = 16'h0000;
    localparam logic [VAL_W-1:0] MAXF_RST = 16'h1770;
    localparam logic [VAL_W-1:0] BRAKE_RST = 16'h0064;

    // Control method choices
    typedef enum logic [1:0] {
        METH_VOLTS_HZ = 2'h0,
        METH_SENSORLESS_VECTOR = 2'h1,
        METH_ECONOMIZE = 2'h2,
        METH_FULL_VECTOR = 2'h3
    } drsac_method_e;

    // Self-tune choices
    typedef enum logic [1:0] {
        TUNE_IDLE = 2'h0,
        TUNE_STATIC = 2'h1,
        TUNE_ROTATE = 2'h2
    } drsac_tune_e;

    // Stop behaviour codes
    localparam logic [2:0] STOP_RAMP_CF = 3'h0;
    localparam logic [2:0] STOP_COAST_CF = 3'h1;
    localparam logic [2:0] STOP_INJ_CF = 3'h2;
    localparam logic [2:0] STOP_INJ_AUTO_CF = 3'h3;
    localparam logic [2:0] STOP_RAMP = 3'h4;
    localparam logic [2:0] STOP_COAST = 3'h5;

    // Drive sequencer states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_RUN = 7'h02,
        ST_RAMP_STOP = 7'h04,
        ST_BRAKE = 7'h08,
        ST_TUNE_ARM = 7'h10,
        ST_TUNE_STATIC = 7'h20,
        ST_TUNE_ROTATE = 7'h40
    } drsac_state_e;
endpackage

/* core/drsac_top.sv */
// Drive run control: method select, self-tune sequencer, ramps, clamping and stop modes
`timescale 1ns/1ps

// Summary of operation
// - Selectable control method, full vector on high model
// - Tune 1: static test stores stator drop
// - Tune 2: static then rotating, stores flux reference
// - Armed tune begins only on start command
// - Tune setting returns to zero when finished
// - No start or a stop in 30 s faults
// - Failed tune raises self-tune fault
// - After tune, running needs new start edge
// - Accel rate is max frequency over accel time
// - Decel rate is max frequency over decel time
// - Output never below minimum frequency in run state after its first cycle, if minimum is not above maximum
// - Output never above maximum frequency unless minimum is set above maximum
// - Stop codes: ramp, coast, injection, auto injection
// - Stop codes 0 to 3 clear active faults
// - Auto injection ends on time or motor stopped
module drsac_top
    import drsac_pkg::*;
#(
    parameter bit HIGH_MODEL = 1'b1,
    parameter longint CENTI_CYC = CENTI_CYCLES,
    parameter longint TUNE_TIMEOUT = TUNE_TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    // Register port
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic [DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [DATA_W-1:0] REG_RDATA_O,
    // Operator commands
    input wire logic START_I,
    input wire logic STOP_I,
    // Power stage feedback
    input wire logic EXT_FAULT_I,
    input wire logic MOTOR_STOPPED_I,
    input wire logic TUNE_DONE_I,
    input wire logic TUNE_FAIL_I,
    input wire logic [VAL_W-1:0] TUNE_RESULT_I,
    // Power stage control
    output logic [VAL_W-1:0] FREQ_O,
    output logic RUN_O,
    output logic DC_BRAKE_O,
    output logic TUNE_STATIC_O,
    output logic TUNE_ROTATE_O,
    output logic [1:0] CTRL_METHOD_O,
    output logic [VAL_W-1:0] STATOR_COMP_O,
    output logic [VAL_W-1:0] FLUX_REF_O,
    // Fault and interrupt
    output logic FAULT_O,
    output logic IRQ_O
);
    drsac_state_e state_q;
    logic [1:0] method_q;
    logic [1:0] tune_q;
    logic [2:0] stop_sel_q;
    logic [VAL_W-1:0] accel_q;
    logic [VAL_W-1:0] decel_q;
    logic [VAL_W-1:0] minf_q;
    logic [VAL_W-1:0] maxf_q;
    logic [VAL_W-1:0] fref_q;
    logic [VAL_W-1:0] brake_q;
    logic [VAL_W-1:0] freq_q;
    logic [VAL_W-1:0] stator_q;
    logic [VAL_W-1:0] flux_q;
    logic [TMR_W-1:0] tmr_q;
    logic [TMR_W-1:0] acc_q;
    logic [TMR_W-1:0] acc_d;
    logic [TMR_W-1:0] ramp_den;
    logic [VAL_W-1:0] target;
    logic start_q;
    logic start_edge;
    logic ev_fault_q;
    logic ev_done_q;
    logic ev_stop_q;
    logic tune_fault_q;
    logic ext_fault_q;
    logic fault_clr;
    logic [IRQ_W-1:0] irq_sts_q;
    logic [IRQ_W-1:0] irq_msk_q;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] rdata_q;
    logic stopped;
    logic cfg_wr;
    logic [VAL_W-1:0] wval;
    logic [VAL_W-1:0] wtime;
    logic [VAL_W-1:0] wfreq;

    // Decoded helpers
    assign stopped = (state_q == ST_IDLE);
    assign cfg_wr = REG_WR_I && (REG_ADDR_I == ADDR_CTRL);
    assign wval = REG_WDATA_I[VAL_W-1:0];
    assign wtime = (wval > TIME_MAX) ? TIME_MAX : wval;   // Out-of-range values saturate
    assign wfreq = (wval > FREQ_LIMIT) ? FREQ_LIMIT : wval;
    assign start_edge = START_I && !start_q;   // Level starts never restart the drive
    assign fault_clr = STOP_I && (stop_sel_q <= STOP_INJ_AUTO_CF);

    // Start edge memory
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            start_q <= 1'b0;
        end else begin
            start_q <= START_I;
        end
    end

    // Settings written by software; motor settings frozen while the drive moves
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            method_q <= METH_SENSORLESS_VECTOR;
            stop_sel_q <= STOP_RAMP_CF;
            accel_q <= ACCEL_RST;
            decel_q <= DECEL_RST;
            minf_q <= MINF_RST;
            maxf_q <= MAXF_RST;
            fref_q <= '0;
            brake_q <= BRAKE_RST;
            irq_msk_q <= '0;
        end else if (REG_WR_I) begin
            case (REG_ADDR_I)
                ADDR_CTRL: begin
                    // Full vector is refused on the smaller model
                    if (stopped && (HIGH_MODEL || REG_WDATA_I[CTRL_METHOD_LSB +: 2] != 2'h3)) begin
                        method_q <= REG_WDATA_I[CTRL_METHOD_LSB +: 2];
                    end
                    // Codes above 5 are kept out of this block
                    if (REG_WDATA_I[CTRL_STOP_LSB +: 3] <= STOP_COAST) begin
                        stop_sel_q <= REG_WDATA_I[CTRL_STOP_LSB +: 3];
                    end
                end
                ADDR_ACCEL: accel_q <= wtime;
                ADDR_DECEL: decel_q <= wtime;
                ADDR_MINF: begin
                    if (stopped) begin
                        minf_q <= wfreq;
                    end
                end
                ADDR_MAXF: begin
                    if (stopped) begin
                        maxf_q <= wfreq;
                    end
                end
                ADDR_FREF: fref_q <= wfreq;
                ADDR_BRAKE: brake_q <= wtime;
                ADDR_IRQ_MSK: irq_msk_q <= REG_WDATA_I[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Drive sequencer: run, stopping, braking and the self-tune steps
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= ST_IDLE;
            tune_q <= TUNE_IDLE;
            tmr_q <= '0;
            stator_q <= '0;
            flux_q <= '0;
            ev_fault_q <= 1'b0;
            ev_done_q <= 1'b0;
            ev_stop_q <= 1'b0;
        end else begin
            ev_fault_q <= 1'b0;
            ev_done_q <= 1'b0;
            ev_stop_q <= 1'b0;
            tmr_q <= tmr_q + 1'b1;
            case (state_q)
                ST_IDLE: begin
                    if (cfg_wr && REG_WDATA_I[CTRL_TUNE_LSB +: 2] != TUNE_IDLE) begin
                        tune_q <= REG_WDATA_I[CTRL_TUNE_LSB +: 2];
                        tmr_q <= '0;
                        state_q <= ST_TUNE_ARM;
                    end else if (start_edge && !FAULT_O) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (FAULT_O) begin
                        state_q <= ST_IDLE;   // A fault drops the gates at once
                        ev_stop_q <= 1'b1;
                    end else if (STOP_I) begin
                        case (stop_sel_q)
                            STOP_COAST_CF, STOP_COAST: begin
                                state_q <= ST_IDLE;
                                ev_stop_q <= 1'b1;
                            end
                            STOP_INJ_CF, STOP_INJ_AUTO_CF: begin
                                tmr_q <= '0;
                                state_q <= ST_BRAKE;
                            end
                            default: state_q <= ST_RAMP_STOP;
                        endcase
                    end
                end
                ST_RAMP_STOP: begin
                    if (FAULT_O || freq_q == '0) begin
                        state_q <= ST_IDLE;
                        ev_stop_q <= 1'b1;
                    end else if (start_edge && !STOP_I) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_BRAKE: begin
                    // Auto mode may end early once the motor reports standstill
                    if (tmr_q >= TMR_W'(brake_q) * TMR_W'(CENTI_CYC) ||
                        (stop_sel_q == STOP_INJ_AUTO_CF && MOTOR_STOPPED_I)) begin
                        state_q <= ST_IDLE;
                        ev_stop_q <= 1'b1;
                    end
                end
                ST_TUNE_ARM: begin
                    if (STOP_I || tmr_q >= TMR_W'(TUNE_TIMEOUT)) begin
                        tune_q <= TUNE_IDLE;
                        ev_fault_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else if (start_edge) begin
                        state_q <= ST_TUNE_STATIC;
                    end
                end
                ST_TUNE_STATIC: begin
                    if (TUNE_FAIL_I || STOP_I) begin
                        tune_q <= TUNE_IDLE;
                        ev_fault_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else if (TUNE_DONE_I) begin
                        stator_q <= TUNE_RESULT_I;
                        if (tune_q == TUNE_ROTATE) begin
                            state_q <= ST_TUNE_ROTATE;
                        end else begin
                            tune_q <= TUNE_IDLE;
                            ev_done_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_TUNE_ROTATE: begin
                    if (TUNE_FAIL_I || STOP_I) begin
                        tune_q <= TUNE_IDLE;
                        ev_fault_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else if (TUNE_DONE_I) begin
                        flux_q <= TUNE_RESULT_I;
                        tune_q <= TUNE_IDLE;
                        ev_done_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Ramp target and step accumulator; adding max frequency every cycle against
    // time x cycles-per-step gives the documented rate without a divider
    always_comb begin
        target = (fref_q > maxf_q) ? maxf_q : fref_q;
        if (target < minf_q) begin
            target = minf_q;
        end
        if (state_q != ST_RUN) begin
            target = '0;
        end
        ramp_den = (freq_q < target) ? TMR_W'(accel_q) * TMR_W'(CENTI_CYC)
                                     : TMR_W'(decel_q) * TMR_W'(CENTI_CYC);
        acc_d = acc_q + TMR_W'(maxf_q);
    end

    // Output frequency ramp; one 0.01 Hz step at most per cycle except for the clamps, zero ramp times and the drop to zero outside run and ramp stop
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            freq_q <= '0;
            acc_q <= '0;
        end else if (state_q != ST_RUN && state_q != ST_RAMP_STOP) begin
            freq_q <= '0;
            acc_q <= '0;
        end else if (state_q == ST_RUN && freq_q < minf_q) begin
            freq_q <= minf_q;   // Start from the floor, not from zero
            acc_q <= '0;
        end else if (state_q == ST_RUN && freq_q > maxf_q) begin
            freq_q <= maxf_q;
            acc_q <= '0;
        end else if (freq_q == target) begin
            acc_q <= '0;   // Hold at target
        end else if (ramp_den == '0) begin
            freq_q <= target;   // Zero time means an instant step
            acc_q <= '0;
        end else if (acc_d >= ramp_den) begin
            freq_q <= (freq_q < target) ? freq_q + 1'b1 : freq_q - 1'b1;
            acc_q <= acc_d - ramp_den;
        end else begin
            acc_q <= acc_d;
        end
    end

    // Latched faults; a new fault in the clearing cycle still lands
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tune_fault_q <= 1'b0;
            ext_fault_q <= 1'b0;
        end else begin
            tune_fault_q <= ev_fault_q || (tune_fault_q && !fault_clr);
            ext_fault_q <= EXT_FAULT_I || (ext_fault_q && !fault_clr);
        end
    end

    // Sticky interrupt status, write one to clear, set beats clear
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_sts_q <= '0;
        end else begin
            irq_sts_q <= (irq_sts_q & ~((REG_WR_I && REG_ADDR_I == ADDR_IRQ_STS) ?
                         REG_WDATA_I[IRQ_W-1:0] : {IRQ_W{1'b0}}))
                         | {ev_stop_q, ev_done_q, ev_fault_q};
        end
    end

    // Read multiplexer; unmapped addresses read as zero
    always_comb begin
        rd_mux = '0;
        case (REG_ADDR_I)
            ADDR_CTRL: begin
                rd_mux[CTRL_METHOD_LSB +: 2] = method_q;
                rd_mux[CTRL_TUNE_LSB +: 2] = tune_q;
                rd_mux[CTRL_STOP_LSB +: 3] = stop_sel_q;
            end
            ADDR_ACCEL: rd_mux[VAL_W-1:0] = accel_q;
            ADDR_DECEL: rd_mux[VAL_W-1:0] = decel_q;
            ADDR_MINF: rd_mux[VAL_W-1:0] = minf_q;
            ADDR_MAXF: rd_mux[VAL_W-1:0] = maxf_q;
            ADDR_FREF: rd_mux[VAL_W-1:0] = fref_q;
            ADDR_BRAKE: rd_mux[VAL_W-1:0] = brake_q;
            ADDR_STAT: begin
                rd_mux[STAT_RUN] = RUN_O;
                rd_mux[STAT_TUNING] = TUNE_STATIC_O || TUNE_ROTATE_O;
                rd_mux[STAT_BRAKE] = DC_BRAKE_O;
                rd_mux[STAT_TUNE_FAULT] = tune_fault_q;
                rd_mux[STAT_EXT_FAULT] = ext_fault_q;
                rd_mux[STAT_STATE_LSB +: 7] = state_q;
            end
            ADDR_OUTF: rd_mux[VAL_W-1:0] = freq_q;
            ADDR_STATOR: rd_mux[VAL_W-1:0] = stator_q;
            ADDR_FLUX: rd_mux[VAL_W-1:0] = flux_q;
            ADDR_IRQ_STS: rd_mux[IRQ_W-1:0] = irq_sts_q;
            ADDR_IRQ_MSK: rd_mux[IRQ_W-1:0] = irq_msk_q;
            default: rd_mux = '0;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= REG_RD_I ? rd_mux : '0;
        end
    end

    // Outputs
    assign REG_RDATA_O = rdata_q;
    assign FREQ_O = freq_q;
    assign RUN_O = (state_q == ST_RUN) || (state_q == ST_RAMP_STOP);
    assign DC_BRAKE_O = (state_q == ST_BRAKE);
    assign TUNE_STATIC_O = (state_q == ST_TUNE_STATIC);
    assign TUNE_ROTATE_O = (state_q == ST_TUNE_ROTATE);
    assign CTRL_METHOD_O = method_q;
    assign STATOR_COMP_O = stator_q;
    assign FLUX_REF_O = flux_q;
    assign FAULT_O = tune_fault_q || ext_fault_q;
    assign IRQ_O = |(irq_sts_q & irq_msk_q);

    // Checks next to the logic above
    method_legal_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        !HIGH_MODEL |-> method_q != METH_FULL_VECTOR) else $error("full vector on small model");
    cfg_frozen_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (!stopped && !$past(stopped)) |-> $stable(minf_q) && $stable(maxf_q) && $stable(method_q))
        else $error("min or max changed while moving");
    static_store_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (state_q == ST_TUNE_STATIC && TUNE_DONE_I && !TUNE_FAIL_I && !STOP_I)
        |=> stator_q == $past(TUNE_RESULT_I)) else $error("stator drop not stored");
    rotate_next_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (state_q == ST_TUNE_STATIC && TUNE_DONE_I && !TUNE_FAIL_I && !STOP_I
         && tune_q == TUNE_ROTATE) |=> state_q == ST_TUNE_ROTATE)
        else $error("rotating test skipped");
    arm_waits_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (state_q == ST_TUNE_ARM && !start_edge) |=> state_q != ST_TUNE_STATIC)
        else $error("tune began without start");
    tune_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (state_q == ST_TUNE_ROTATE && TUNE_DONE_I) |=> tune_q == TUNE_IDLE && state_q == ST_IDLE)
        else $error("tune setting not cleared");
    arm_timeout_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (state_q == ST_TUNE_ARM && (STOP_I || tmr_q >= TMR_W'(TUNE_TIMEOUT)))
        |=> tune_q == TUNE_IDLE ##1 tune_fault_q) else $error("arm timeout lost");
    tune_fail_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (TUNE_STATIC_O || TUNE_ROTATE_O) && TUNE_FAIL_I |=> ##1 FAULT_O)
        else $error("failed tune without fault");
    new_start_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && !start_edge) |=> state_q != ST_RUN)
        else $error("ran without start edge");
    freq_clamp_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        ((state_q == ST_RUN)[*2] ##0 (minf_q < maxf_q))
        |-> freq_q >= minf_q && freq_q <= maxf_q) else $error("frequency outside limits");
    ramp_step_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        ((state_q == ST_RUN)[*2] ##0 (accel_q != '0 && decel_q != '0
         && $past(freq_q) >= minf_q && $past(freq_q) <= maxf_q))
        |-> (freq_q - $past(freq_q) <= 16'h0001) || ($past(freq_q) - freq_q <= 16'h0001))
        else $error("ramp stepped too far");
    coast_stop_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (state_q == ST_RUN && !FAULT_O && STOP_I
         && (stop_sel_q == STOP_COAST_CF || stop_sel_q == STOP_COAST))
        |=> state_q == ST_IDLE ##1 freq_q == '0) else $error("coast stop not immediate");
    stop_clears_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (fault_clr && !EXT_FAULT_I && !ev_fault_q) |=> !FAULT_O)
        else $error("stop did not clear fault");
    brake_early_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (state_q == ST_BRAKE && stop_sel_q == STOP_INJ_AUTO_CF && MOTOR_STOPPED_I)
        |=> state_q == ST_IDLE) else $error("auto brake ignored standstill");
endmodule

/* testbench/drsac_stage.sv */
// Power stage model that answers self-tune steps
`timescale 1ns/1ps
module drsac_stage (
    // Clock and requests
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic test_i,
    input wire logic bad_i,
    input wire logic [15:0] val_i,
    input wire logic [15:0] freq_i,
    // Answers
    output logic done_o,
    output logic fail_o,
    output logic [15:0] res_o,
    output logic halt_o
);
    logic [2:0] cnt_q;
    // The static step answers five cycles after it begins and the rotating step seven, so a test never ends at once
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) cnt_q <= 3'h0;
        else cnt_q <= test_i ? cnt_q + 3'h1 : 3'h0;
    end
    // Result is inverted away from done to expose early sampling
    assign done_o = test_i && cnt_q == 3'h5 && !bad_i;
    assign fail_o = test_i && cnt_q == 3'h5 && bad_i;
    assign res_o = done_o ? val_i : ~val_i;
    // Motor rests once no frequency is applied
    assign halt_o = freq_i == 16'h0000;
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the drive run controller
`timescale 1ns/1ps
module tb_top;
    import drsac_pkg::*;
    logic clk, rst_n, wr, rd, go, st, dn, fl, hl, bad, run, brk, ts, tr, flt, irq, ef;
    logic [7:0] ad;
    logic [31:0] wd, rdat;
    logic [15:0] res, frq, val, stc, flx;
    logic [1:0] meth;
    int err_count, n_compared, cyc, n, tgt;
    drsac_top #(.CENTI_CYC(10), .TUNE_TIMEOUT(200)) i_dut (.SYS_CLK_I(clk),
        .RST_N_I(rst_n), .REG_ADDR_I(ad), .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdat), .START_I(go), .STOP_I(st), .EXT_FAULT_I(ef),
        .MOTOR_STOPPED_I(hl), .TUNE_DONE_I(dn), .TUNE_FAIL_I(fl), .TUNE_RESULT_I(res),
        .FREQ_O(frq), .RUN_O(run), .DC_BRAKE_O(brk), .TUNE_STATIC_O(ts),
        .TUNE_ROTATE_O(tr), .CTRL_METHOD_O(meth), .STATOR_COMP_O(stc),
        .FLUX_REF_O(flx), .FAULT_O(flt), .IRQ_O(irq));
    drsac_stage i_stage (.clk_i(clk), .rst_n_i(rst_n), .test_i(ts | tr), .bad_i(bad),
        .val_i(val), .freq_i(frq), .done_o(dn), .fail_o(fl), .res_o(res), .halt_o(hl));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang limit far above the few thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (err_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // Write, or read and compare in the cycle after the strobe
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {wr, rd, ad, wd} <= {w, !w, a, v};
        @(posedge clk);
        {wr, rd} <= 2'h0;
        #1 if (!w) chk("register", v, rdat);
    endtask
    // One-cycle start or stop command
    task automatic cmd(input logic [1:0] gs);
        @(posedge clk);
        {go, st} <= gs;
        @(posedge clk);
        {go, st} <= 2'h0;
        #1;
    endtask
    initial begin
        {rst_n, wr, rd, go, st, bad, ef, ad, wd} = '0;
        void'($urandom(14935));
        val = 16'($urandom());
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, ADDR_CTRL, 32'h1);
        bus(0, ADDR_ACCEL, 32'(ACCEL_RST));
        bus(0, ADDR_MAXF, 32'(MAXF_RST));
        bus(0, 8'h40, 32'h0);
        bus(1, ADDR_MAXF, 32'hEA60);
        bus(0, ADDR_MAXF, 32'(FREQ_LIMIT));
        bus(1, ADDR_CTRL, 32'h3);
        chk("method", 32'h3, 32'(meth));
        // Ramp times give one 0.01 Hz step every second cycle
        bus(1, ADDR_MAXF, 32'h64);
        bus(1, ADDR_MINF, 32'h14);
        bus(1, ADDR_ACCEL, 32'h14);
        bus(1, ADDR_DECEL, 32'h14);
        bus(1, ADDR_FREF, 32'(val));
        tgt = val > 100 ? 100 : val < 20 ? 20 : val;
        // Run up and stop once in every stop code
        for (int c = 0; c < 6; c++) begin
            bus(1, ADDR_CTRL, c << 8);
            cmd(2'h2);
            for (n = 0; n < 200 && frq != tgt; n++) @(negedge clk);
            chk("ramp end", tgt, frq);
            n = n - (tgt - 20) * 2;
            chk("ramp time", 1, 32'(n > -4 && n < 5));
            cmd(2'h1);
            chk("stop kind", {c % 4 == 0, c == 2 || c == 3}, {run, brk});
            for (n = 0; n < 1100 && (run || brk); n++) @(negedge clk);
            repeat (2) @(negedge clk);
            chk("stopped", 0, frq);
            if (c == 2 || c == 3) chk("brake time", 32'(c == 2), 32'(n > 900));
        end
        // Static then rotating tune; the start stays high afterwards
        for (int t = 1; t < 3; t++) begin
            bus(1, ADDR_CTRL, t << 4);
            @(posedge clk);
            go <= 1'b1;
            for (n = 0; n < 40 && !(ts || tr); n++) @(negedge clk);
            for (n = 0; n < 40 && (ts || tr); n++) @(negedge clk);
            chk("tune value", val, t == 1 ? stc : flx);
            bus(0, ADDR_CTRL, 32'h0);
            chk("held start", 0, run);
            @(posedge clk);
            go <= 1'b0;
        end
        // Arming timeout, its interrupt, then clearing by stop code
        bus(1, ADDR_IRQ_MSK, 32'h1);
        bus(1, ADDR_IRQ_STS, 32'h7);
        bus(1, ADDR_CTRL, 32'h10);
        for (n = 0; n < 300 && !flt; n++) @(negedge clk);
        chk("timeout", 1, 32'(n > 195 && n < 206));
        chk("irq", 1, irq);
        bus(0, ADDR_CTRL, 32'h0);
        bus(1, ADDR_IRQ_STS, 32'h1);
        chk("irq clear", 0, irq);
        bus(1, ADDR_CTRL, 32'h400);
        cmd(2'h1);
        @(negedge clk);
        chk("fault kept", 1, flt);
        bus(1, ADDR_CTRL, 32'h0);
        cmd(2'h1);
        @(negedge clk);
        chk("fault cleared", 0, flt);
        // One-cycle power stage fault latches until a clearing stop
        ef <= 1'b1;
        @(posedge clk);
        ef <= 1'b0;
        #1 chk("ext fault", 1, flt);
        cmd(2'h1);
        @(negedge clk);
        chk("ext cleared", 0, flt);
        bad <= 1'b1;
        bus(1, ADDR_CTRL, 32'h10);
        cmd(2'h2);
        for (n = 0; n < 40 && !flt; n++) @(negedge clk);
        chk("tune failure", 1, flt);
        tally_and_finish();
    end
endmodule
